// ==== logic/chb_addr_compare.sv ====
// Purpose: Channel B address comparison, combinational.
// Assumes: Bus values stable for the cycle they are presented.
// Notes:   X/Y accesses are words, so bit 0 never takes part.
`default_nettype none

module chb_addr_compare (
    // Selected bus set.
    input  wire logic        xye_i,
    input  wire logic        xys_i,
    // Compare value and mask halves.
    input  wire logic [15:0] cmp_high_i,
    input  wire logic [15:0] cmp_low_i,
    input  wire logic [15:0] msk_high_i,
    input  wire logic [15:0] msk_low_i,
    // Watched buses.
    input  wire logic [31:0] addr_bus_i,
    input  wire logic [15:0] x_addr_i,
    input  wire logic [15:0] y_addr_i,
    // Result.
    output logic             match_o
);

    // Bit 0 forced into the mask in X/Y mode.
    localparam logic [15:0] BIT0_MASK = 16'h0001;

    wire logic hi_int; // Upper half against internal address.
    wire logic lo_int; // Lower half against internal address.
    wire logic x_hit;  // X address against upper half.
    wire logic y_hit;  // Y address against lower half.

    assign hi_int = chb_match_pkg::masked_eq(addr_bus_i[31:16], cmp_high_i, msk_high_i); // R1 R4
    assign lo_int = chb_match_pkg::masked_eq(addr_bus_i[15:0], cmp_low_i, msk_low_i); // R1 R4
    assign x_hit  = chb_match_pkg::masked_eq(x_addr_i, cmp_high_i, msk_high_i | BIT0_MASK); // R2 R5
    assign y_hit  = chb_match_pkg::masked_eq(y_addr_i, cmp_low_i, msk_low_i | BIT0_MASK); // R2 R5

    // Select the comparison the control bits ask for.
    assign match_o = !xye_i ? (hi_int & lo_int) : (xys_i ? y_hit : x_hit); // R9

endmodule

`default_nettype wire

// ==== logic/chb_data_compare.sv ====
// Purpose: Channel B data comparison, combinational.
// Assumes: Data buses valid in the cycle the bus strobe is high.
// Notes:   No data mask here; all selected bits take part.
`default_nettype none

module chb_data_compare (
    // Selected bus set.
    input  wire logic        xye_i,
    input  wire logic        xys_i,
    // Compare value halves.
    input  wire logic [15:0] cmp_high_i,
    input  wire logic [15:0] cmp_low_i,
    // Watched buses.
    input  wire logic [31:0] data_bus_i,
    input  wire logic [15:0] x_data_i,
    input  wire logic [15:0] y_data_i,
    // Result.
    output logic             match_o
);

    wire logic full_hit; // Internal data bus against both halves.
    wire logic x_hit;    // X data against upper half.
    wire logic y_hit;    // Y data against lower half.

    assign full_hit = (data_bus_i == {cmp_high_i, cmp_low_i}); // R6
    assign x_hit    = (x_data_i == cmp_high_i); // R7
    assign y_hit    = (y_data_i == cmp_low_i); // R7

    // The select bit only counts once X/Y mode is on.
    assign match_o = !xye_i ? full_hit : (xys_i ? y_hit : x_hit); // R9

endmodule

`default_nettype wire

// ==== logic/chb_match.sv ====
// Purpose: Channel B break address and data match with register file.
// Assumes: Watched buses come from logic on clk_i; no synchroniser needed.
// Notes:   Match outputs are registered, so they show one cycle after the bus.
//
// Chosen here: the placing of the registers and the Wishbone register port.
`default_nettype none

module chb_match (
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Watched buses.
    input  wire logic        bus_valid_i,
    input  wire logic [31:0] addr_bus_i,
    input  wire logic [31:0] data_bus_i,
    input  wire logic [15:0] x_addr_i,
    input  wire logic [15:0] y_addr_i,
    input  wire logic [15:0] x_data_i,
    input  wire logic [15:0] y_data_i,
    // Results and bus select.
    output logic             addr_match_o,
    output logic             data_match_o,
    output logic             xy_bus_enable_o,
    output logic             x_or_y_select_o,
    output logic             irq_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register state.
    // Every register is a plain flop cleared by the synchronous reset.
    // The control word holds only the two select bits and the data
    // enable; the bus-cycle type fields live in a neighbouring block.
    // Only the status bits change without a write, and only upwards.

    logic [15:0] chb_compare_address_high_q; // Upper compare address half.
    logic [15:0] chb_compare_address_low_q;  // Lower compare address half.
    logic [15:0] chb_addr_mask_high_q;       // Upper address mask half.
    logic [15:0] chb_addr_mask_low_q;        // Lower address mask half.
    logic [15:0] chb_compare_data_high_q;    // Upper compare data half.
    logic [15:0] chb_compare_data_low_q;     // Lower compare data half.

    // Control, status and bus answer state.
    logic [2:0]  ctl_q;                      // Select and data enable bits.
    logic [1:0]  status_q;                   // Sticky match events.
    logic [1:0]  irq_mask_q;                 // Interrupt enables.
    logic        ack_q;                      // Bus acknowledge.
    logic [31:0] rdata_q;                    // Registered read data.

    // Registered results.
    logic        addr_match_q;               // Registered address match.
    logic        data_match_q;               // Registered data match.
    logic        irq_q;                      // Registered interrupt.

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode.

    wire logic        req;      // New request not yet answered.
    wire logic        wr;       // Write strobe for this cycle.
    wire logic        lo_lanes; // Both low byte lanes selected.
    wire logic [15:0] wr_half;  // Low half of write data; lo_lanes gates its use.

    wire logic        hit_ah;   // Address decode hits.
    wire logic        hit_al;
    wire logic        hit_mh;
    wire logic        hit_ml;
    wire logic        hit_dh;
    wire logic        hit_dl;
    wire logic        hit_ct;
    wire logic        hit_st;
    wire logic        hit_im;

    // A single-cycle answer; the ack flop blocks a second take of one request.
    // Holding stb up after the ack gets the request taken again, as
    // classic Wishbone allows, so the master must drop it.
    // A half changes only with lanes 0 and 1 both on, so it never tears.
    assign req      = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr       = req & wb_we_i;
    assign lo_lanes = wb_sel_i[0] & wb_sel_i[1];
    assign wr_half  = wb_dat_i[15:0];

    // Exact byte address decode; anything else misses every word,
    // reads as zero and has its write ignored.
    assign hit_ah = (wb_adr_i == chb_match_pkg::OFF_ADDR_HIGH);
    assign hit_al = (wb_adr_i == chb_match_pkg::OFF_ADDR_LOW);
    assign hit_mh = (wb_adr_i == chb_match_pkg::OFF_MASK_HIGH);
    assign hit_ml = (wb_adr_i == chb_match_pkg::OFF_MASK_LOW);
    assign hit_dh = (wb_adr_i == chb_match_pkg::OFF_DATA_HIGH);
    assign hit_dl = (wb_adr_i == chb_match_pkg::OFF_DATA_LOW);
    assign hit_ct = (wb_adr_i == chb_match_pkg::OFF_CONTROL);
    assign hit_st = (wb_adr_i == chb_match_pkg::OFF_STATUS);
    assign hit_im = (wb_adr_i == chb_match_pkg::OFF_IRQ_MASK);

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped words read as zero and still get an ack.
    // Registered every cycle; the value taken with the ack is the one
    // captured at the edge that took the request.

    logic [31:0] rmux;

    always_comb begin
        rmux = 32'h0000_0000;
        if (hit_ah) begin
            // Compare address, upper half.
            rmux[15:0] = chb_compare_address_high_q;
        end else if (hit_al) begin
            // Compare address, lower half.
            rmux[15:0] = chb_compare_address_low_q;
        end else if (hit_mh) begin
            // Address mask, upper half.
            rmux[15:0] = chb_addr_mask_high_q;
        end else if (hit_ml) begin
            // Address mask, lower half.
            rmux[15:0] = chb_addr_mask_low_q;
        end else if (hit_dh) begin
            // Compare data, upper half.
            rmux[15:0] = chb_compare_data_high_q;
        end else if (hit_dl) begin
            // Compare data, lower half.
            rmux[15:0] = chb_compare_data_low_q;
        end else if (hit_ct) begin
            // Select and data enable bits.
            rmux[2:0] = ctl_q;
        end else if (hit_st) begin
            // Sticky match events.
            rmux[1:0] = status_q;
        end else if (hit_im) begin
            // Interrupt enables.
            rmux[1:0] = irq_mask_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Comparators.
    // Both are pure logic on the current bus values, so a match is
    // judged inside its own cycle and registered at its end.
    // One pair of select bits steers both, so they watch one bus set.

    wire logic addr_hit; // Address condition met now.
    wire logic data_hit; // Data condition met now.

    // Masked address compare.
    chb_addr_compare u_addr (
        .xye_i      (ctl_q[chb_match_pkg::CTL_XYE_BIT]),
        .xys_i      (ctl_q[chb_match_pkg::CTL_XYS_BIT]),
        .cmp_high_i (chb_compare_address_high_q),
        .cmp_low_i  (chb_compare_address_low_q),
        .msk_high_i (chb_addr_mask_high_q),
        .msk_low_i  (chb_addr_mask_low_q),
        .addr_bus_i (addr_bus_i),
        .x_addr_i   (x_addr_i),
        .y_addr_i   (y_addr_i),
        .match_o    (addr_hit)
    );

    // Exact data compare on the selected bus.
    chb_data_compare u_data (
        .xye_i      (ctl_q[chb_match_pkg::CTL_XYE_BIT]),
        .xys_i      (ctl_q[chb_match_pkg::CTL_XYS_BIT]),
        .cmp_high_i (chb_compare_data_high_q),
        .cmp_low_i  (chb_compare_data_low_q),
        .data_bus_i (data_bus_i),
        .x_data_i   (x_data_i),
        .y_data_i   (y_data_i),
        .match_o    (data_hit)
    );

    // Data only counts when software enabled it; it then owes an operand size.
    wire logic addr_ev; // Address match in a watched cycle.
    wire logic data_ev; // Data match in a watched cycle.

    assign addr_ev = bus_valid_i & addr_hit; // R12
    assign data_ev = bus_valid_i & data_hit & ctl_q[chb_match_pkg::CTL_DEN_BIT]; // R11 R12

    ////////////////////////////////////////////////////////////////////////////////
    // Status next value: set wins over a write-one clear in the same cycle.
    // Letting the set win means an event on the clear cycle is never
    // lost; software sees it at its next status read.
    // Both clear bits sit in the low byte, so lane 0 alone carries them.

    wire logic [1:0] st_clr; // Bits software clears now.
    wire logic [1:0] st_set; // Bits hardware sets now.
    wire logic [1:0] st_d;   // Next status.

    assign st_clr = (wr & hit_st & wb_sel_i[0]) ? wb_dat_i[1:0] : chb_match_pkg::ST_RESET;
    assign st_set = {data_ev, addr_ev};
    assign st_d   = (status_q & ~st_clr) | st_set;

    ////////////////////////////////////////////////////////////////////////////////
    // Compare address halves; byte lanes 0 and 1 both needed for a write.
    // One write reaches one half; each half is its own word.

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chb_compare_address_high_q <= chb_match_pkg::HALF_RESET; // R10
            chb_compare_address_low_q  <= chb_match_pkg::HALF_RESET; // R10
        end else if (wr & lo_lanes & hit_ah) begin
            chb_compare_address_high_q <= wr_half; // R10
        end else if (wr & lo_lanes & hit_al) begin
            chb_compare_address_low_q <= wr_half; // R10
        end
    end

    // Address mask halves.
    // A one in a mask bit drops that bit from the compare.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chb_addr_mask_high_q <= chb_match_pkg::HALF_RESET; // R8
            chb_addr_mask_low_q  <= chb_match_pkg::HALF_RESET; // R8
        end else if (wr & lo_lanes & hit_mh) begin
            chb_addr_mask_high_q <= wr_half; // R3
        end else if (wr & lo_lanes & hit_ml) begin
            chb_addr_mask_low_q <= wr_half; // R3
        end
    end

    // Compare data halves.
    // No mask applies to data; every selected bit must agree.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chb_compare_data_high_q <= chb_match_pkg::HALF_RESET; // R8
            chb_compare_data_low_q  <= chb_match_pkg::HALF_RESET; // R8
        end else if (wr & lo_lanes & hit_dh) begin
            chb_compare_data_high_q <= wr_half; // R8
        end else if (wr & lo_lanes & hit_dl) begin
            chb_compare_data_low_q <= wr_half; // R8
        end
    end

    // Control bits need only lane 0.
    // Bits above the field are dropped and read back as zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_q <= chb_match_pkg::CTL_RESET;
        end else if (wr & wb_sel_i[0] & hit_ct) begin
            ctl_q <= wb_dat_i[2:0]; // R9
        end
    end

    // Interrupt mask.
    // Same layout as the status word; a one lets that event interrupt.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_q <= chb_match_pkg::ST_RESET;
        end else if (wr & wb_sel_i[0] & hit_im) begin
            irq_mask_q <= wb_dat_i[1:0];
        end
    end

    // Sticky status, interrupt level and match outputs.
    // The level is built from the next status value, so irq_o rises
    // with the match pulse that caused it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_q     <= chb_match_pkg::ST_RESET;
            irq_q        <= 1'b0;
            addr_match_q <= 1'b0;
            data_match_q <= 1'b0;
        end else begin
            // All four follow every cycle.
            status_q     <= st_d;
            irq_q        <= |(st_d & irq_mask_q);
            addr_match_q <= addr_ev; // R12
            data_match_q <= data_ev; // R12
        end
    end

    // Bus answer one cycle after the request is seen.
    // The read data flop loads every cycle; only the ack makes it count.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            // Answer the request seen at this edge.
            ack_q   <= req;
            rdata_q <= rmux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs, each straight from a flop.
    // The select bits go out so the far side can steer its own
    // bus multiplexers without a register read.

    assign wb_ack_o        = ack_q;
    assign wb_dat_o        = rdata_q;
    assign addr_match_o    = addr_match_q;
    assign data_match_o    = data_match_q;
    assign xy_bus_enable_o = ctl_q[chb_match_pkg::CTL_XYE_BIT];
    assign x_or_y_select_o = ctl_q[chb_match_pkg::CTL_XYS_BIT];
    assign irq_o           = irq_q;

endmodule

`default_nettype wire

// ==== logic/chb_match_pkg.sv ====
// Summary of operation
// R1: Internal mode compares upper and lower address halves.
// R2: X/Y mode compares bits 15..1 only.
// R3: Mask bit one drops that address bit.
// R4: Each mask half applies to its half.
// R5: X/Y mode masks only the selected half.
// R6: Internal mode compares data halves to bus.
// R7: X/Y mode: upper is X, lower Y.
// R8: Mask and data halves reset to zero.
// R9: Enable picks bus set; select picks X/Y.
// R10: Compare address held as two halves.
// R11: Software sets operand size with data. This block has no operand size field, only the data enable bit.
// R12: Match flagged when unmasked bits all agree.
//
// Purpose: Shared constants for the channel B match block.
// Assumes: 32-bit classic Wishbone slave, one word per register.
// Notes:   Register halves are 16 bits in the low data lanes.
`default_nettype none

package chb_match_pkg;

    // Widths of the watched buses, register halves and Wishbone address.
    localparam int unsigned HALF_W = 16;
    localparam int unsigned FULL_W = 32;
    localparam int unsigned WB_AW  = 8;

    // Byte offsets of the register words.
    localparam logic [WB_AW-1:0] OFF_ADDR_HIGH = 8'h00;
    localparam logic [WB_AW-1:0] OFF_ADDR_LOW  = 8'h04;
    localparam logic [WB_AW-1:0] OFF_MASK_HIGH = 8'h08;
    localparam logic [WB_AW-1:0] OFF_MASK_LOW  = 8'h0C;
    localparam logic [WB_AW-1:0] OFF_DATA_HIGH = 8'h10;
    localparam logic [WB_AW-1:0] OFF_DATA_LOW  = 8'h14;
    localparam logic [WB_AW-1:0] OFF_CONTROL   = 8'h18;
    localparam logic [WB_AW-1:0] OFF_STATUS    = 8'h1C;
    localparam logic [WB_AW-1:0] OFF_IRQ_MASK  = 8'h20;

    // Reset value of every 16-bit register half.
    localparam logic [HALF_W-1:0] HALF_RESET = 16'h0000;

    // Control register fields.
    localparam int unsigned CTL_XYS_BIT  = 0;
    localparam int unsigned CTL_XYE_BIT  = 1;
    localparam int unsigned CTL_DEN_BIT  = 2;
    localparam int unsigned CTL_W        = 3;
    localparam logic [CTL_W-1:0] CTL_RESET = 3'h0;

    // Status and interrupt mask fields.
    localparam int unsigned ST_ADDR_BIT = 0;
    localparam int unsigned ST_DATA_BIT = 1;
    localparam int unsigned ST_W        = 2;
    localparam logic [ST_W-1:0] ST_RESET = 2'h0;

    // Equal where the mask is zero; a set mask bit never blocks a match.
    function automatic logic masked_eq(input logic [HALF_W-1:0] bus_v,
                                       input logic [HALF_W-1:0] cmp_v,
                                       input logic [HALF_W-1:0] msk_v);
        masked_eq = ((bus_v ^ cmp_v) & ~msk_v) == HALF_RESET;
    endfunction

endpackage

`default_nettype wire

// ==== verif/bus_cycle_model.sv ====
// Purpose: Core and transfer-engine bus cycles seen by the match block.
// Assumes: Buses change just after a rising edge.
// Notes:   A released bus shows the inverse of its last value, never a held copy.
`default_nettype none

module bus_cycle_model (
    // Clock.
    input  wire logic        clk_i,
    // Watched buses.
    output logic             bus_valid_o,
    output logic [31:0]      addr_o,
    output logic [31:0]      data_o,
    output logic [15:0]      xa_o,
    output logic [15:0]      ya_o
);
    initial begin
        {bus_valid_o, addr_o, data_o, xa_o, ya_o} = '0;
    end

    // One cycle after an optional idle gap; X/Y data lanes reuse the X/Y address values.
    task automatic drive(input logic v, input logic [31:0] a, input logic [31:0] d,
                         input logic [15:0] x, input logic [15:0] y, input int gap);
        repeat (gap) @(posedge clk_i);
        @(posedge clk_i);
        bus_valid_o <= v;
        addr_o      <= a;
        data_o      <= d;
        xa_o        <= x;
        ya_o        <= y;
        @(posedge clk_i);
        bus_valid_o <= 1'b0;
        addr_o      <= ~a;
        data_o      <= ~d;
        xa_o        <= ~x;
        ya_o        <= ~y;
    endtask
endmodule

`default_nettype wire

// ==== verif/chb_match_checker.sv ====
// Purpose: Port assertions for the channel B match block.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Register contents are judged by the bench, not here.
`default_nettype none

module chb_match_checker (
    // Clock and reset.
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Wishbone slave.
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Watch side and results.
    input wire logic        bus_valid_i,
    input wire logic        addr_match_o,
    input wire logic        data_match_o,
    input wire logic        xy_bus_enable_o,
    input wire logic        x_or_y_select_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // A request that the slave has not answered yet.
    sequence wb_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // A read of the first word past the map.
    sequence wb_unmapped_rd;
        wb_req ##0 (!wb_we_i && wb_adr_i == 8'h24);
    endsequence

    chk_ack_next_edge: assert property (wb_req |=> wb_ack_o)
        else $error("ack missing one cycle after a request");
    chk_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack stood longer than one cycle");
    chk_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without a request");
    chk_unmapped_reads_zero: assert property (wb_unmapped_rd |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read returned nonzero data");
    chk_addr_needs_valid: assert property (!bus_valid_i |=> !addr_match_o)
        else $error("address match without a bus cycle");
    chk_data_needs_valid: assert property (!bus_valid_i |=> !data_match_o)
        else $error("data match without a bus cycle");
    // Bus selection moves only with an acknowledged write.
    chk_select_on_write: assert property ($changed({xy_bus_enable_o, x_or_y_select_o}) |-> wb_ack_o && wb_we_i)
        else $error("bus select changed without a write");
    chk_irq_rise_cause: assert property ($rose(irq_o) |-> addr_match_o || data_match_o || $past(wb_ack_o))
        else $error("interrupt rose with no match or write");
    chk_irq_fall_cause: assert property ($fell(irq_o) |-> wb_ack_o || $past(wb_ack_o))
        else $error("interrupt fell with no write");
endmodule

bind chb_match chb_match_checker u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .bus_valid_i(bus_valid_i), .addr_match_o(addr_match_o), .data_match_o(data_match_o),
    .xy_bus_enable_o(xy_bus_enable_o), .x_or_y_select_o(x_or_y_select_o), .irq_o(irq_o)
);

`default_nettype wire

// ==== verif/chb_match_tb_top.sv ====
// Purpose: Self-checking bench for the channel B match block.
// Assumes: Wishbone classic master, one request at a time.
// Notes:   Compare address is 1234_5678, compare data BEEF_CAFE.
`default_nettype none

module chb_match_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_i, rst_i, cyc, stb, we;
    logic [7:0]  adr;
    logic [31:0] dat, rdat, wb_dat_o;
    logic        wb_ack_o, addr_match_o, data_match_o, xy_en, xy_sel, irq_o;
    logic        bv;
    logic [31:0] ab, db;
    logic [15:0] xa, ya;
    int          n_fail, comparisons, cycles;

    bus_cycle_model u_bus (.clk_i(clk_i), .bus_valid_o(bv), .addr_o(ab), .data_o(db), .xa_o(xa), .ya_o(ya));

    chb_match dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .bus_valid_i(bv), .addr_bus_i(ab), .data_bus_i(db), .x_addr_i(xa), .y_addr_i(ya),
        .x_data_i(xa), .y_data_i(ya), .addr_match_o(addr_match_o), .data_match_o(data_match_o),
        .xy_bus_enable_o(xy_en), .x_or_y_select_o(xy_sel), .irq_o(irq_o)
    );

    always #2.5 clk_i = ~clk_i;

    // A hang counts as a mismatch and closes the run.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 4000) begin
            n_fail++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Classic single cycle; the answer is taken only at the edge that samples ack.
    task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) begin
            @(posedge clk_i);
        end
        rdat = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        wb_cycle(1'b0, a, 32'h0000_0000);
        check("register read", rdat, exp);
    endtask

    // Program the control word, run one bus cycle, then judge both match pulses.
    task automatic probe(input logic [2:0] ctl, input logic v, input logic [31:0] a, input logic [31:0] d,
                         input logic [15:0] x, input logic [15:0] y, input logic ea, input logic ed);
        wb_cycle(1'b1, 8'h18, {29'h0000_0000, ctl});
        check("bus select", {30'h0000_0000, xy_en, xy_sel}, {30'h0000_0000, ctl[1:0]});
        u_bus.drive(v, a, d, x, y, int'(ctl[0]));
        #1;
        check("addr_match_o", {31'h0000_0000, addr_match_o}, {31'h0000_0000, ea});
        check("data_match_o", {31'h0000_0000, data_match_o}, {31'h0000_0000, ed});
    endtask

    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        {cyc, stb, we, adr, dat} = 43'h000_0000_0000;
        {n_fail, comparisons, cycles} = '0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i <= 9; i++) rd_chk(8'(i * 4), 32'h0000_0000);
        wb_cycle(1'b1, 8'h08, 32'hFFFF_A5C3);
        rd_chk(8'h08, 32'h0000_A5C3);
        wb_cycle(1'b1, 8'h24, 32'hFFFF_FFFF);
        rd_chk(8'h24, 32'h0000_0000);
        wb_cycle(1'b1, 8'h00, 32'h0000_1234);
        wb_cycle(1'b1, 8'h04, 32'h0000_5678);
        rd_chk(8'h04, 32'h0000_5678);
        wb_cycle(1'b1, 8'h08, 32'h0000_0000);
        wb_cycle(1'b1, 8'h10, 32'h0000_BEEF);
        wb_cycle(1'b1, 8'h14, 32'h0000_CAFE);
        $display("test registers done");
        probe(3'h0, 1'b1, 32'h1234_5678, 32'h0, 16'h0, 16'h0, 1'b1, 1'b0);
        probe(3'h0, 1'b0, 32'h1234_5678, 32'h0, 16'h0, 16'h0, 1'b0, 1'b0);
        probe(3'h0, 1'b1, 32'h1234_5679, 32'h0, 16'h0, 16'h0, 1'b0, 1'b0);
        probe(3'h0, 1'b1, 32'h9234_5678, 32'h0, 16'h0, 16'h0, 1'b0, 1'b0);
        probe(3'h2, 1'b1, 32'h0, 32'h0, 16'h1235, 16'h0, 1'b1, 1'b0);
        probe(3'h2, 1'b1, 32'h1234_5678, 32'h0, 16'h0, 16'h1234, 1'b0, 1'b0);
        probe(3'h3, 1'b1, 32'h0, 32'h0, 16'h0, 16'h5679, 1'b1, 1'b0);
        probe(3'h3, 1'b1, 32'h0, 32'h0, 16'h5678, 16'h1234, 1'b0, 1'b0);
        wb_cycle(1'b1, 8'h08, 32'h0000_0003);
        wb_cycle(1'b1, 8'h0C, 32'h0000_8000);
        probe(3'h0, 1'b1, 32'h1237_5678, 32'h0, 16'h0, 16'h0, 1'b1, 1'b0);
        probe(3'h0, 1'b1, 32'h1234_567B, 32'h0, 16'h0, 16'h0, 1'b0, 1'b0);
        probe(3'h0, 1'b1, 32'h1234_D678, 32'h0, 16'h0, 16'h0, 1'b1, 1'b0);
        probe(3'h2, 1'b1, 32'h0, 32'h0, 16'h1236, 16'h0, 1'b1, 1'b0);
        probe(3'h2, 1'b1, 32'h0, 32'h0, 16'h9234, 16'h0, 1'b0, 1'b0);
        probe(3'h3, 1'b1, 32'h0, 32'h0, 16'h0, 16'hD678, 1'b1, 1'b0);
        probe(3'h3, 1'b1, 32'h0, 32'h0, 16'h0, 16'h567A, 1'b0, 1'b0);
        $display("test address done");
        // Operand size lives outside this block, so only the data enable is set here.
        probe(3'h4, 1'b1, 32'h0, 32'hBEEF_CAFE, 16'h0, 16'h0, 1'b0, 1'b1);
        probe(3'h0, 1'b1, 32'h0, 32'hBEEF_CAFE, 16'h0, 16'h0, 1'b0, 1'b0);
        probe(3'h4, 1'b1, 32'h0, 32'hBEEF_CAFF, 16'h0, 16'h0, 1'b0, 1'b0);
        probe(3'h6, 1'b1, 32'h0, 32'h0, 16'hBEEF, 16'h0, 1'b0, 1'b1);
        probe(3'h7, 1'b1, 32'h0, 32'h0, 16'h0, 16'hCAFE, 1'b0, 1'b1);
        probe(3'h6, 1'b1, 32'h0, 32'h0, 16'hCAFE, 16'hBEEF, 1'b0, 1'b0);
        $display("test data done");
        rd_chk(8'h1C, 32'h0000_0003);
        check("irq_o", {31'h0000_0000, irq_o}, 32'h0000_0000);
        wb_cycle(1'b1, 8'h20, 32'h0000_0001);
        #1;
        check("irq_o", {31'h0000_0000, irq_o}, 32'h0000_0001);
        wb_cycle(1'b1, 8'h1C, 32'h0000_0001);
        #1;
        check("irq_o", {31'h0000_0000, irq_o}, 32'h0000_0000);
        rd_chk(8'h1C, 32'h0000_0002);
        $display("test interrupt done");
        wrap_up();
    end
endmodule

`default_nettype wire
